// *** bsm_pkg.sv ***
package bsm_pkg;

	localparam int              IR_W          = 2;
	localparam int              ID_W          = 32;
	localparam logic [1:0]      IR_BYPASS     = 2'h3;
	localparam logic [1:0]      IR_IDCODE     = 2'h1;
	localparam logic [1:0]      IR_RESET_VAL  = 2'h1;
	localparam logic [1:0]      IR_CAPTURE    = 2'h1;
	// arbitrary identification value; bit 0 must stay set
	localparam logic [31:0]     ID_CODE_DEF   = 32'h0000_0001;
	localparam int              TLR_TMS_HIGHS = 5;

	typedef enum logic [3:0] {
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} bsm_tap_t;

endpackage

// *** bsm_tap_fsm.sv ***
`timescale 1ns/1ps
`default_nettype none
module bsm_tap_fsm (
	input  wire logic      tck,
	input  wire logic      rst_n,
	input  wire logic      ce,
	input  wire logic      hold,
	input  wire logic      tms,
	output var bsm_pkg::bsm_tap_t state
);

	bsm_pkg::bsm_tap_t state_reg;
	bsm_pkg::bsm_tap_t state_next;

	assign state = state_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bsm_pkg::TAP_RESET:    state_next = tms ? bsm_pkg::TAP_RESET : bsm_pkg::TAP_IDLE;
			bsm_pkg::TAP_IDLE:     state_next = tms ? bsm_pkg::TAP_SEL_DR : bsm_pkg::TAP_IDLE;
			bsm_pkg::TAP_SEL_DR:   state_next = tms ? bsm_pkg::TAP_SEL_IR : bsm_pkg::TAP_CAP_DR;
			bsm_pkg::TAP_CAP_DR:   state_next = tms ? bsm_pkg::TAP_EXIT1_DR : bsm_pkg::TAP_SHIFT_DR;
			bsm_pkg::TAP_SHIFT_DR: state_next = tms ? bsm_pkg::TAP_EXIT1_DR : bsm_pkg::TAP_SHIFT_DR;
			bsm_pkg::TAP_EXIT1_DR: state_next = tms ? bsm_pkg::TAP_UPD_DR : bsm_pkg::TAP_PAUSE_DR;
			bsm_pkg::TAP_PAUSE_DR: state_next = tms ? bsm_pkg::TAP_EXIT2_DR : bsm_pkg::TAP_PAUSE_DR;
			bsm_pkg::TAP_EXIT2_DR: state_next = tms ? bsm_pkg::TAP_UPD_DR : bsm_pkg::TAP_SHIFT_DR;
			bsm_pkg::TAP_UPD_DR:   state_next = tms ? bsm_pkg::TAP_SEL_DR : bsm_pkg::TAP_IDLE;
			bsm_pkg::TAP_SEL_IR:   state_next = tms ? bsm_pkg::TAP_RESET : bsm_pkg::TAP_CAP_IR;
			bsm_pkg::TAP_CAP_IR:   state_next = tms ? bsm_pkg::TAP_EXIT1_IR : bsm_pkg::TAP_SHIFT_IR;
			bsm_pkg::TAP_SHIFT_IR: state_next = tms ? bsm_pkg::TAP_EXIT1_IR : bsm_pkg::TAP_SHIFT_IR;
			bsm_pkg::TAP_EXIT1_IR: state_next = tms ? bsm_pkg::TAP_UPD_IR : bsm_pkg::TAP_PAUSE_IR;
			bsm_pkg::TAP_PAUSE_IR: state_next = tms ? bsm_pkg::TAP_EXIT2_IR : bsm_pkg::TAP_PAUSE_IR;
			bsm_pkg::TAP_EXIT2_IR: state_next = tms ? bsm_pkg::TAP_UPD_IR : bsm_pkg::TAP_SHIFT_IR;
			bsm_pkg::TAP_UPD_IR:   state_next = tms ? bsm_pkg::TAP_SEL_DR : bsm_pkg::TAP_IDLE;
		endcase
	end

	always_ff @(posedge tck) begin
		if (!rst_n || hold) begin
			state_reg <= bsm_pkg::TAP_RESET;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	tms_five_high_a: assert property (@(posedge tck) disable iff (!rst_n)
		(ce && tms && !hold) [*5] |=> state_reg == bsm_pkg::TAP_RESET)
		else $error("tap not in reset after five high tms edges");

	idle_from_reset_a: assert property (@(posedge tck) disable iff (!rst_n)
		(state_reg == bsm_pkg::TAP_RESET && ce && !tms && !hold)
			|=> state_reg == bsm_pkg::TAP_IDLE)
		else $error("tap did not leave reset on low tms");

	held_in_reset_a: assert property (@(posedge tck) disable iff (!rst_n)
		hold |=> state_reg == bsm_pkg::TAP_RESET)
		else $error("tap left reset while held");

endmodule
`default_nettype wire

// *** bsm_port_mode.sv ***
// Behaviour
// - mode taken only from program fuse, fixed
// - unblown fuse means flexible mode
// - dedicated mode: test pins never user I/O
// - flexible mode: tdi and tdo pins usable as user I/O, tck pin as user input only
// - dedicated mode enables tms and tdi pull-ups
// - flexible mode: low tms starts test operation
// - dedicated mode: tms steers standard tap machine
`timescale 1ns/1ps
`default_nettype none
module bsm_port_mode #(
	parameter logic [31:0] ID_CODE = bsm_pkg::ID_CODE_DEF
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic tck,
	input  wire logic fuse_blown,
	input  wire logic tms,
	input  wire logic tdi_in,
	output logic      tdi_out,
	output logic      tdi_oe,
	input  wire logic tdo_in,
	output logic      tdo_out,
	output logic      tdo_oe,
	output logic      tms_pullup_en,
	output logic      tdi_pullup_en,
	output logic      user_tck_in,
	output logic      user_tdi_in,
	output logic      user_tdo_in,
	input  wire logic user_tdi_d,
	input  wire logic user_tdi_en,
	input  wire logic user_tdo_d,
	input  wire logic user_tdo_en,
	output logic      mode_dedicated,
	output logic      test_active
);

	// ---------------- clk domain ----------------
	logic fuse_m_reg, fuse_s_reg;
	logic fuse_valid_reg, dedicated_reg;
	logic tms_m_reg, tms_s_reg;
	logic tck_m_reg, tck_s_reg;
	logic tdi_m_reg, tdi_s_reg;
	logic tdo_m_reg, tdo_s_reg;
	logic tlr_m_reg, tlr_s_reg;
	// written in the tck domain below; only tlr_m_reg reads it here
	logic tlr_t_reg;
	logic test_active_reg;
	logic test_own;
	logic test_start;
	logic user_tdi_oe_reg, user_tdi_d_reg;
	logic user_tdo_oe_reg, user_tdo_d_reg;
	logic user_tck_in_reg, user_tdi_in_reg, user_tdo_in_reg;

	always_ff @(posedge clk) begin
		if (ce) begin
			fuse_m_reg <= fuse_blown;
			fuse_s_reg <= fuse_m_reg;
			tms_m_reg  <= tms;
			tms_s_reg  <= tms_m_reg;
			tck_m_reg  <= tck;
			tck_s_reg  <= tck_m_reg;
			tdi_m_reg  <= tdi_in;
			tdi_s_reg  <= tdi_m_reg;
			tdo_m_reg  <= tdo_in;
			tdo_s_reg  <= tdo_m_reg;
			tlr_m_reg  <= tlr_t_reg;
			tlr_s_reg  <= tlr_m_reg;
		end
	end

	// the fuse is sampled once after reset and then frozen until the next reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fuse_valid_reg <= 1'b0;
			dedicated_reg  <= 1'b0;
		end else if (ce && !fuse_valid_reg) begin
			fuse_valid_reg <= 1'b1;
			dedicated_reg  <= fuse_s_reg;
		end
	end

	assign test_start = fuse_valid_reg && !dedicated_reg && !tms_s_reg;
	assign test_own   = dedicated_reg || test_active_reg;

	// test ends only once tms is back high and the tap has fallen to reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			test_active_reg <= 1'b0;
		end else if (ce) begin
			if (test_start) begin
				test_active_reg <= 1'b1;
			end else if (tms_s_reg && tlr_s_reg) begin
				test_active_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			user_tdi_oe_reg <= 1'b0;
			user_tdi_d_reg  <= 1'b0;
			user_tdo_oe_reg <= 1'b0;
			user_tdo_d_reg  <= 1'b0;
		end else if (ce) begin
			user_tdi_oe_reg <= user_tdi_en && !test_own;
			user_tdi_d_reg  <= user_tdi_d;
			user_tdo_oe_reg <= user_tdo_en && !test_own;
			user_tdo_d_reg  <= user_tdo_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			user_tck_in_reg <= 1'b0;
			user_tdi_in_reg <= 1'b0;
			user_tdo_in_reg <= 1'b0;
		end else if (ce) begin
			user_tck_in_reg <= tck_s_reg && !test_own;
			user_tdi_in_reg <= tdi_s_reg && !test_own;
			user_tdo_in_reg <= tdo_s_reg && !test_own;
		end
	end

	assign user_tck_in    = user_tck_in_reg;
	assign user_tdi_in    = user_tdi_in_reg;
	assign user_tdo_in    = user_tdo_in_reg;
	assign tms_pullup_en  = dedicated_reg;
	assign tdi_pullup_en  = dedicated_reg;
	assign mode_dedicated = dedicated_reg;
	assign test_active    = test_active_reg;

	// ---------------- tck domain ----------------
	logic                       trst_m_reg, trst_s_reg;
	logic                       own_m_reg, own_s_reg;
	logic                       ce_m_reg, ce_s_reg;
	logic                       tap_hold;
	logic [bsm_pkg::IR_W-1:0]   ir_sh_reg, ir_reg;
	logic [bsm_pkg::ID_W-1:0]   id_sh_reg;
	logic                       byp_reg;
	logic                       tdo_tap_reg, tdo_tap_oe_reg;
	bsm_pkg::bsm_tap_t          tap_state;

	always_ff @(posedge tck) begin
		trst_m_reg <= rst_n;
		trst_s_reg <= trst_m_reg;
		own_m_reg  <= test_own;
		own_s_reg  <= own_m_reg;
		ce_m_reg   <= ce;
		ce_s_reg   <= ce_m_reg;
	end

	assign tap_hold = !own_s_reg;

	bsm_tap_fsm u_tap (
		.tck   (tck),
		.rst_n (trst_s_reg),
		.ce    (ce_s_reg),
		.hold  (tap_hold),
		.tms   (tms),
		.state (tap_state)
	);

	always_ff @(posedge tck) begin
		tlr_t_reg <= (tap_state == bsm_pkg::TAP_RESET);
	end

	always_ff @(posedge tck) begin
		if (!trst_s_reg || tap_state == bsm_pkg::TAP_RESET) begin
			ir_reg    <= bsm_pkg::IR_RESET_VAL;
			ir_sh_reg <= bsm_pkg::IR_RESET_VAL;
		end else if (ce_s_reg) begin
			unique case (tap_state)
				bsm_pkg::TAP_CAP_IR:   ir_sh_reg <= bsm_pkg::IR_CAPTURE;
				bsm_pkg::TAP_SHIFT_IR: ir_sh_reg <= {tdi_in, ir_sh_reg[bsm_pkg::IR_W-1:1]};
				bsm_pkg::TAP_UPD_IR:   ir_reg    <= ir_sh_reg;
				default: begin
				end
			endcase
		end
	end

	// any opcode other than the identification one selects bypass
	always_ff @(posedge tck) begin
		if (!trst_s_reg) begin
			id_sh_reg <= '0;
			byp_reg   <= 1'b0;
		end else if (ce_s_reg) begin
			if (tap_state == bsm_pkg::TAP_CAP_DR) begin
				id_sh_reg <= ID_CODE;
				byp_reg   <= 1'b0;
			end else if (tap_state == bsm_pkg::TAP_SHIFT_DR) begin
				id_sh_reg <= {tdi_in, id_sh_reg[bsm_pkg::ID_W-1:1]};
				byp_reg   <= tdi_in;
			end
		end
	end

	// tdo changes on the falling tck edge so the controller samples it stable
	always_ff @(negedge tck) begin
		if (!trst_s_reg) begin
			tdo_tap_reg    <= 1'b0;
			tdo_tap_oe_reg <= 1'b0;
		end else if (ce_s_reg) begin
			tdo_tap_oe_reg <= own_s_reg && (tap_state == bsm_pkg::TAP_SHIFT_IR
				|| tap_state == bsm_pkg::TAP_SHIFT_DR);
			if (tap_state == bsm_pkg::TAP_SHIFT_IR) begin
				tdo_tap_reg <= ir_sh_reg[0];
			end else if (ir_reg == bsm_pkg::IR_IDCODE) begin
				tdo_tap_reg <= id_sh_reg[0];
			end else begin
				tdo_tap_reg <= byp_reg;
			end
		end
	end

	// user drive is already off whenever the tap can shift, so the or never fights
	assign tdi_out = user_tdi_d_reg;
	assign tdi_oe  = user_tdi_oe_reg;
	assign tdo_out = tdo_tap_oe_reg ? tdo_tap_reg : user_tdo_d_reg;
	assign tdo_oe  = tdo_tap_oe_reg || user_tdo_oe_reg;

	fuse_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
		fuse_valid_reg |=> fuse_valid_reg && dedicated_reg == $past(dedicated_reg))
		else $error("mode changed after fuse was sampled");

	flex_default_a: assert property (@(posedge clk) disable iff (!rst_n)
		!fuse_valid_reg |-> !mode_dedicated && !tms_pullup_en)
		else $error("dedicated mode before fuse sampled");

	dedicated_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
		(dedicated_reg && ce) |=> !tdi_oe && !user_tdo_oe_reg && !user_tdi_in
			&& !user_tdo_in && !user_tck_in)
		else $error("user logic reached a test pin in dedicated mode");

	flex_user_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !dedicated_reg && !test_active_reg) |=> tdi_oe == $past(user_tdi_en)
			&& user_tdo_oe_reg == $past(user_tdo_en) && tdi_out == $past(user_tdi_d))
		else $error("flexible pins did not follow user logic");

	pullup_on_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !fuse_valid_reg && fuse_s_reg) |=> tms_pullup_en && tdi_pullup_en)
		else $error("pull-ups not enabled for blown fuse");

	test_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && test_start) |=> test_active_reg ##1 (!ce || !user_tdi_oe_reg))
		else $error("low tms did not start test operation");

	idle_user_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !test_own && tdi_s_reg) |=> user_tdi_in)
		else $error("user input not passed while test idle");

endmodule
`default_nettype wire

// *** bsm_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bsm_ctrl_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// tck stands still low between frames; tms idles high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// static levels, used when the pins act as user inputs
	task automatic set_pins(input logic c, input logic m, input logic d);
		tck = c;
		tms = m;
		tdi = d;
	endtask

	// one test clock period; tdo is taken on the rising edge
	task automatic tick(input logic m, output logic q);
		tms = m;
		tdi = ~tdi;
		#6 tck = 1'b1;
		q = tdo;
		#6 tck = 1'b0;
	endtask

	// from idle or reset: shift out the identification value, then back to reset
	task automatic read_id(output logic [31:0] v);
		logic q;
		tick(1'b0, q);
		tick(1'b1, q);
		tick(1'b0, q);
		tick(1'b0, q);
		for (int i = 0; i < 32; i++) begin
			tick(i == 31, q);
			v[i] = q;
		end
		// tms left high so that a flexible-mode test ends afterwards
		repeat (bsm_pkg::TLR_TMS_HIGHS + 1) tick(1'b1, q);
	endtask

	// from idle or reset: capture the instruction bits and load c, end in idle
	task automatic load_ir(input logic [1:0] c, output logic [1:0] cap);
		logic q;
		tick(1'b0, q);
		tick(1'b1, q);
		tick(1'b1, q);
		tick(1'b0, q);
		tick(1'b0, q);
		// tick inverts tdi first, so preset the inverse of the wanted bit
		tdi = ~c[0];
		tick(1'b0, cap[0]);
		tdi = ~c[1];
		tick(1'b1, cap[1]);
		tick(1'b1, q);
		tick(1'b0, q);
	endtask
endmodule
`default_nettype wire

// *** bsm_port_mode_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module bsm_port_mode_tb;
	logic        clk, rst_n, ce, fuse_blown, tdo_ext, ded_e, act_e, q;
	logic        user_tdi_d, user_tdi_en, user_tdo_d, user_tdo_en;
	wire logic   tck, tms, tdi_c, tdi_in, tdo_in, tdi_out, tdi_oe, tdo_out, tdo_oe;
	wire logic   tms_pullup_en, tdi_pullup_en, user_tck_in, user_tdi_in, user_tdo_in;
	wire logic   mode_dedicated, test_active;
	int          bad_count, samples_checked;
	logic [31:0] rd;
	logic [3:0]  r;
	logic [1:0]  cp;

	assign tdi_in = tdi_oe ? tdi_out : tdi_c;
	assign tdo_in = tdo_oe ? tdo_out : tdo_ext;

	bsm_port_mode bsm_port_mode_i (.clk(clk), .rst_n(rst_n), .ce(ce), .tck(tck),
		.fuse_blown(fuse_blown), .tms(tms), .tdi_in(tdi_in), .tdi_out(tdi_out),
		.tdi_oe(tdi_oe), .tdo_in(tdo_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
		.tms_pullup_en(tms_pullup_en), .tdi_pullup_en(tdi_pullup_en),
		.user_tck_in(user_tck_in), .user_tdi_in(user_tdi_in), .user_tdo_in(user_tdo_in),
		.user_tdi_d(user_tdi_d), .user_tdi_en(user_tdi_en), .user_tdo_d(user_tdo_d),
		.user_tdo_en(user_tdo_en), .mode_dedicated(mode_dedicated),
		.test_active(test_active));

	bsm_ctrl_model bsm_ctrl_model_i (.tck(tck), .tms(tms), .tdi(tdi_c), .tdo(tdo_in));

	// pins belong to user logic only in flexible mode outside a test
	function automatic logic exp_user(input logic v);
		return v & ~ded_e & ~act_e;
	endfunction

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic do_reset(input logic f);
		fuse_blown = f;
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		// the test clock must run for the tap domain to see reset
		repeat (3) bsm_ctrl_model_i.tick(1'b1, q);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		ded_e = f;
		act_e = 1'b0;
		`CHK(mode_dedicated, f)
		`CHK({tms_pullup_en, tdi_pullup_en}, {f, f})
		`CHK(tdo_oe, 1'b0)
	endtask

	task automatic user_drive(input int n);
		repeat (n) begin
			r = 4'($urandom);
			{user_tdi_d, user_tdi_en, user_tdo_d, user_tdo_en} = r;
			@(negedge clk);
			`CHK({tdi_oe, tdo_oe}, {exp_user(r[2]), exp_user(r[0])})
			`CHK(tdi_out & tdi_oe, exp_user(r[3] & r[2]))
			`CHK(tdo_out & tdo_oe, exp_user(r[1] & r[0]))
		end
	endtask

	task automatic user_in(input int n);
		{user_tdi_en, user_tdo_en} = 2'b00;
		repeat (n) begin
			r = 4'($urandom);
			bsm_ctrl_model_i.set_pins(r[0], 1'b1, r[1]);
			tdo_ext = r[2];
			repeat (4) @(negedge clk);
			`CHK(user_tck_in, exp_user(r[0]))
			`CHK({user_tdi_in, user_tdo_in}, {exp_user(r[1]), exp_user(r[2])})
		end
	endtask

	task automatic wait_act(input logic v);
		int k;
		k = 0;
		while (test_active !== v && k < 20) begin
			@(negedge clk);
			k++;
		end
		if (k == 20) begin
			bad_count++;
			finish_test();
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test();
	end

	initial begin
		{rst_n, ce, fuse_blown, tdo_ext, ded_e, act_e} = 6'b01_0000;
		{user_tdi_d, user_tdi_en, user_tdo_d, user_tdo_en} = 4'h0;
		bad_count = 0;
		samples_checked = 0;
		void'($urandom(32'h0000_81cf));
		do_reset(1'b0);
		user_drive(8);
		user_in(6);
		// flexible mode: a low tms takes the pins over for test
		bsm_ctrl_model_i.set_pins(1'b0, 1'b0, 1'b0);
		wait_act(1'b1);
		act_e = 1'b1;
		user_drive(4);
		`CHK(user_tdi_in, 1'b0)
		repeat (3) bsm_ctrl_model_i.tick(1'b0, q);
		bsm_ctrl_model_i.read_id(rd);
		`CHK(rd, bsm_pkg::ID_CODE_DEF)
		wait_act(1'b0);
		act_e = 1'b0;
		user_drive(4);
		// enable low: the pin registers keep the last request whatever comes next
		ce = 1'b0;
		{user_tdi_d, user_tdi_en, user_tdo_d, user_tdo_en} = ~r;
		repeat (3) @(negedge clk);
		`CHK({tdi_out, tdi_oe, tdo_out, tdo_oe}, r)
		ce = 1'b1;
		@(negedge clk);
		`CHK({tdi_out, tdi_oe, tdo_out, tdo_oe}, ~r)
		// dedicated mode, entered by a second reset mid-run
		do_reset(1'b1);
		fuse_blown = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(mode_dedicated, 1'b1)
		user_drive(8);
		user_in(4);
		`CHK(test_active, 1'b0)
		bsm_ctrl_model_i.set_pins(1'b0, 1'b1, 1'b0);
		repeat (5) bsm_ctrl_model_i.tick(1'b1, q);
		bsm_ctrl_model_i.read_id(rd);
		`CHK(rd, bsm_pkg::ID_CODE_DEF)
		`CHK(tdo_oe, 1'b0)
		// bypass: one captured zero, then each tdi bit returns one clock late
		bsm_ctrl_model_i.load_ir(bsm_pkg::IR_BYPASS, cp);
		`CHK(cp, bsm_pkg::IR_CAPTURE)
		bsm_ctrl_model_i.read_id(rd);
		`CHK(rd[0], 1'b0)
		`CHK(rd[31:2] ^ rd[30:1], 30'h3fff_ffff)
		finish_test();
	end
endmodule
`default_nettype wire
